/* core/mmbd_pkg.sv */
package mmbd_pkg;
  // ----------------------------------------
  // program memory
  // ----------------------------------------
  localparam int unsigned PC_W        = 13;
  localparam int unsigned INSN_W      = 14;
  localparam int unsigned PADDR_SMALL = 10;   // 1K words
  localparam int unsigned PADDR_LARGE = 11;   // 2K words
  localparam logic [12:0] RESET_VEC   = 13'h0000;
  localparam logic [12:0] IRQ_VEC     = 13'h0004;

  // ----------------------------------------
  // data memory
  // ----------------------------------------
  localparam int unsigned DADDR_W     = 8;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned DIR_W       = 7;
  localparam int unsigned RAM_AW      = 8;    // 176 bytes of storage
  localparam int unsigned RAM_DEPTH   = 176;
  localparam logic [7:0]  SFR_TOP     = 8'h1F;
  localparam logic [7:0]  GPR0_LO_S   = 8'h40;
  localparam logic [7:0]  GPR0_LO_L   = 8'h20;
  localparam logic [7:0]  GPR0_HI     = 8'h7F;
  localparam logic [7:0]  GPR1_LO     = 8'hA0;
  localparam logic [7:0]  GPR1_HI     = 8'hEF;
  localparam logic [7:0]  MIRROR_LO   = 8'hF0;
  localparam logic [7:0]  MIRROR_OFS  = 8'h80;  // F0h..FFh -> 70h..7Fh
  localparam logic [7:0]  RAM0_OFS    = 8'h20;  // 20h..7Fh -> ram 00h..5Fh
  localparam logic [7:0]  RAM1_OFS    = 8'h40;  // A0h..EFh -> ram 60h..AFh
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;

  typedef enum logic [1:0]
  {
    MMBD_SEL_NONE = 2'b00,
    MMBD_SEL_SFR  = 2'b01,
    MMBD_SEL_RAM  = 2'b10
  } mmbd_sel_t;
endpackage : mmbd_pkg

/* core/mmbd_ram.sv */
// ----------------------------------------
// general purpose ram, registered read
// ----------------------------------------
module mmbd_ram
  import mmbd_pkg::*;
(
  input  wire logic                          ref_clk_in,
  input  wire logic                          we_in,
  input  wire logic [mmbd_pkg::RAM_AW-1:0]   addr_in,
  input  wire logic [mmbd_pkg::DATA_W-1:0]   wdata_in,
  output logic      [mmbd_pkg::DATA_W-1:0]   rdata_out
);
  logic [DATA_W-1:0] mem [RAM_DEPTH];

  // no reset: contents survive bank switches and are never cleared
  always_ff @(posedge ref_clk_in)
  begin
    if (we_in)
    begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end
endmodule : mmbd_ram

/* core/mmbd_top.sv */
// Summary of operation
// RQ1: program counter is 13 bits, logical space 8K words of 14 bits.
// RQ2: small variant implements program words 0000h to 03FFh only.
// RQ3: large variant implements program words 0000h to 07FFh.
// RQ4: program addresses beyond implemented size wrap, upper counter bits ignored.
// RQ5: fetch starts at 0000h after reset; interrupt loads 0004h.
// RQ6: data memory has two banks, each with special and general registers.
// RQ7: lowest 32 locations of each bank decode as special function registers.
// RQ8: small variant maps bank 0 40h-7Fh onto general purpose ram.
// RQ9: large variant maps bank 0 20h-7Fh and bank 1 A0h-EFh onto ram.
// RQ10: bank 1 F0h-FFh reach the same storage as bank 0 70h-7Fh.
// RQ11: unimplemented locations read zero and ignore writes.
// RQ12: bank select bit 0 selects bank 0, 1 selects bank 1.
// RQ13: software keeps indirect bank bit and upper bank select bit at zero.
// RQ14: registers reachable by direct address or through the file select pointer.
// RQ15: direct address is bank select bit above 7-bit instruction field.
// RQ16: ram contents survive bank switches; selection only changes decoding.
module mmbd_top
  import mmbd_pkg::*;
#(
  parameter bit LARGE_MEM = 1'b0
)
(
  input  wire logic                          ref_clk_in,
  input  wire logic                          rst_b_in,
  input  wire logic                          pc_load_in,
  input  wire logic [mmbd_pkg::PC_W-1:0]     pc_load_val_in,
  input  wire logic                          pc_inc_in,
  input  wire logic                          irq_take_in,
  input  wire logic                          bank_select_bit_in,
  input  wire logic                          upper_bank_select_bit_in,
  input  wire logic                          indirect_bank_bit_in,
  input  wire logic                          dacc_in,
  input  wire logic                          dacc_indirect_in,
  input  wire logic [mmbd_pkg::DIR_W-1:0]    dir_addr_in,
  input  wire logic [mmbd_pkg::DADDR_W-1:0]  file_select_pointer_in,
  input  wire logic                          dwrite_in,
  input  wire logic [mmbd_pkg::DATA_W-1:0]   dwdata_in,
  input  wire logic [mmbd_pkg::DATA_W-1:0]   sfr_rdata_in,
  output logic      [mmbd_pkg::PC_W-1:0]     pc_out,
  output logic      [mmbd_pkg::PC_W-1:0]     fetch_addr_out,
  output logic                               sfr_sel_out,
  output logic                               sfr_we_out,
  output logic      [4:0]                    sfr_addr_out,
  output logic      [mmbd_pkg::DATA_W-1:0]   sfr_wdata_out,
  output logic      [mmbd_pkg::DATA_W-1:0]   drdata_out,
  output logic                               dvalid_out
);
  import mmbd_pkg::*;

  // ----------------------------------------
  // program counter and fetch address
  // ----------------------------------------
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [PC_W-1:0] fetch_r;
  logic [PC_W-1:0] fetch_nxt;
  logic [PC_W-1:0] wrap_mask;
  logic [PC_W-1:0] pc_plus1;

  // the counter wraps at its own 13-bit width, never at the array size
  assign pc_plus1 = PC_W'(pc_r + 13'h0001);                          // RQ1

  // interrupt wins over load, load over increment
  assign pc_nxt = irq_take_in ? IRQ_VEC                              // RQ5
                : pc_load_in  ? pc_load_val_in
                : pc_inc_in   ? pc_plus1
                : pc_r;

  // upper counter bits are kept but ignored by the array,
  // so a jump above the array lands on its low image
  assign wrap_mask = LARGE_MEM ? PC_W'((1 << PADDR_LARGE) - 1)       // RQ3
                               : PC_W'((1 << PADDR_SMALL) - 1);      // RQ2
  assign fetch_nxt = pc_nxt & wrap_mask;                             // RQ4

  // reset vector comes straight from the reset value;
  // fetch keeps its own flop so the array address never sees the adder
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pc_r    <= RESET_VEC;                                          // RQ5
      fetch_r <= RESET_VEC;
    end
    else
    begin
      pc_r    <= pc_nxt;
      fetch_r <= fetch_nxt;
    end
  end

  // outputs leave straight from the counter and fetch flops
  assign pc_out         = pc_r;
  assign fetch_addr_out = fetch_r;

  // ----------------------------------------
  // data address formation and decode
  // ----------------------------------------
  logic [DADDR_W-1:0] daddr;
  logic               bank1;
  logic [DIR_W-1:0]   low7;
  logic               is_sfr;
  logic               is_gpr0;
  logic               is_gpr1;
  logic               is_mirror;
  logic               is_ram;
  logic [RAM_AW-1:0]  ram_addr;
  logic [DADDR_W-1:0] fold_addr;
  logic [DADDR_W-1:0] gpr0_lo;
  logic [RAM_AW-1:0]  ram0_idx;
  logic [RAM_AW-1:0]  ram1_idx;
  mmbd_sel_t          sel;

  // reserved status bits are assumed zero, so only the low pointer byte matters;
  // limitation: the indirect and upper bank inputs are not decoded at all, so a
  // program that sets them still reaches banks 0 and 1 only
  assign daddr = dacc_indirect_in ? file_select_pointer_in           // RQ14
                                  : {bank_select_bit_in, dir_addr_in}; // RQ15 RQ12

  // bank bit and in-bank offset of the formed address
  assign bank1 = daddr[DADDR_W-1];                                   // RQ6
  assign low7  = daddr[DIR_W-1:0];

  // bank 0 ram starts lower on the large variant
  assign gpr0_lo   = LARGE_MEM ? GPR0_LO_L : GPR0_LO_S;              // RQ8 RQ9

  assign is_sfr    = ({1'b0, low7} <= SFR_TOP);                      // RQ7
  assign is_gpr0   = !bank1 && (daddr >= gpr0_lo) && (daddr <= GPR0_HI); // RQ8 RQ9
  assign is_gpr1   = LARGE_MEM && (daddr >= GPR1_LO) && (daddr <= GPR1_HI); // RQ9
  assign is_mirror = (daddr >= MIRROR_LO);                           // RQ10
  assign is_ram    = is_gpr0 || is_gpr1 || is_mirror;

  // mirror folds onto 70h-7Fh first, so both banks land on one cell
  assign fold_addr = is_mirror ? daddr - MIRROR_OFS : daddr;         // RQ10

  // bank 0 ram starts at cell 00h and bank 1 packs right above it;
  // a shared 7-bit index would let bank 1 overwrite bank 0 cells
  // cell map: 00h-5Fh bank 0 (20h-7Fh), 60h-AFh bank 1 (A0h-EFh);
  // the small variant leaves cells 00h-1Fh and 60h-AFh unused
  assign ram0_idx = RAM_AW'(fold_addr - RAM0_OFS);                   // RQ8 RQ9
  assign ram1_idx = RAM_AW'(daddr - RAM1_OFS);                       // RQ9 RQ16
  assign ram_addr = is_gpr1 ? ram1_idx : ram0_idx;

  // special registers win; anything unmapped reads back as zero
  assign sel = is_sfr ? MMBD_SEL_SFR : is_ram ? MMBD_SEL_RAM : MMBD_SEL_NONE;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [DATA_W-1:0] ram_rdata;
  logic              ram_we;

  // writes to holes are dropped here; reads of holes still clock the array,
  // but their data never reach the answer because the select is registered
  assign ram_we = dacc_in && dwrite_in && (sel == MMBD_SEL_RAM);     // RQ11 RQ16

  mmbd_ram u_ram
  (
    .ref_clk_in (ref_clk_in),
    .we_in      (ram_we),
    .addr_in    (ram_addr),
    .wdata_in   (dwdata_in),
    .rdata_out  (ram_rdata)
  );

  // ----------------------------------------
  // answer path, one cycle after the access
  // ----------------------------------------
  mmbd_sel_t          sel_r;
  logic               dvalid_r;
  logic               sfr_sel_r;
  logic               sfr_we_r;
  logic [4:0]         sfr_addr_r;
  logic [DATA_W-1:0]  sfr_wdata_r;
  logic               sfr_hit;
  logic               sfr_wr;

  // strobes for the special register file sitting outside this block
  assign sfr_hit = dacc_in && (sel == MMBD_SEL_SFR);                 // RQ7
  assign sfr_wr  = sfr_hit && dwrite_in;

  // answer strobes last one cycle; address and data follow every cycle
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sel_r       <= MMBD_SEL_NONE;
      dvalid_r    <= 1'b0;
      sfr_sel_r   <= 1'b0;
      sfr_we_r    <= 1'b0;
      sfr_addr_r  <= 5'h00;
      sfr_wdata_r <= ZERO_BYTE;
    end
    else
    begin
      sel_r       <= dacc_in ? sel : MMBD_SEL_NONE;
      dvalid_r    <= dacc_in;
      sfr_sel_r   <= sfr_hit;                                        // RQ7
      sfr_we_r    <= sfr_wr;
      sfr_addr_r  <= low7[4:0];
      sfr_wdata_r <= dwdata_in;
    end
  end

  // ram read data is registered in the memory, so the mux follows it;
  // trade-off: the special register data arrive from outside in this same
  // cycle, so this one output is a mux of flops rather than a flop itself
  always_comb
  begin
    unique case (sel_r)
      MMBD_SEL_SFR:  drdata_out = sfr_rdata_in;
      MMBD_SEL_RAM:  drdata_out = ram_rdata;
      MMBD_SEL_NONE: drdata_out = ZERO_BYTE;                         // RQ11
      default:       drdata_out = ZERO_BYTE;
    endcase
  end

  assign dvalid_out    = dvalid_r;
  assign sfr_sel_out   = sfr_sel_r;
  assign sfr_we_out    = sfr_we_r;
  assign sfr_addr_out  = sfr_addr_r;
  assign sfr_wdata_out = sfr_wdata_r;
endmodule : mmbd_top

/* verification/mmbd_sfr_model.sv */
// ----------------------------------------
// special register file outside the block
// ----------------------------------------
module mmbd_sfr_model
  import mmbd_pkg::*;
(
  input  wire logic [4:0]                  sfr_addr_in,
  output logic      [mmbd_pkg::DATA_W-1:0] sfr_rdata_out
);
  // a pattern unique per slot, so a wrong slot shows
  assign sfr_rdata_out = {3'h5, sfr_addr_in};
endmodule : mmbd_sfr_model

/* verification/mmbd_top_checker.sv */
// ----------------------------------------
// decode checker
// ----------------------------------------
module mmbd_top_checker
  import mmbd_pkg::*;
#(
  parameter bit LARGE_MEM = 1'b0
)
(
  input wire logic                         ref_clk_in,
  input wire logic                         rst_b_in,
  input wire logic                         pc_load_in,
  input wire logic [mmbd_pkg::PC_W-1:0]    pc_load_val_in,
  input wire logic                         irq_take_in,
  input wire logic                         bank_select_bit_in,
  input wire logic                         dacc_in,
  input wire logic                         dacc_indirect_in,
  input wire logic [mmbd_pkg::DIR_W-1:0]   dir_addr_in,
  input wire logic [mmbd_pkg::PC_W-1:0]    pc_out,
  input wire logic [mmbd_pkg::PC_W-1:0]    fetch_addr_out,
  input wire logic                         sfr_sel_out,
  input wire logic [mmbd_pkg::DATA_W-1:0]  drdata_out,
  input wire logic                         dvalid_out
);
  wire       direct = dacc_in && !dacc_indirect_in;
  wire [12:0] mask  = LARGE_MEM ? 13'h07FF : 13'h03FF;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // each answer belongs to exactly one taken access
  AST_DVALID: assert property (dacc_in |=> dvalid_out) else $error("missing data valid");
  AST_IDLE: assert property (!dacc_in |=> !dvalid_out) else $error("spurious data valid");
  AST_IRQ: assert property (irq_take_in |=> pc_out == IRQ_VEC) else $error("bad interrupt vector");
  AST_LOAD: assert property (pc_load_in && !irq_take_in |=> pc_out == $past(pc_load_val_in))
    else $error("bad program counter load");
  // upper counter bits never reach the fetch address
  AST_WRAP: assert property (fetch_addr_out == (pc_out & mask)) else $error("fetch not wrapped");
  AST_SFR: assert property (direct && dir_addr_in < 7'h20 |=> sfr_sel_out) else $error("low slot not special");
  AST_NOSFR: assert property (direct && dir_addr_in >= 7'h20 |=> !sfr_sel_out) else $error("bad special decode");
  AST_ZERO: assert property (direct && !LARGE_MEM && !bank_select_bit_in && dir_addr_in[6:5] == 2'b01
    |=> drdata_out == ZERO_BYTE) else $error("hole not zero");
endmodule : mmbd_top_checker

bind mmbd_top mmbd_top_checker #(.LARGE_MEM(LARGE_MEM)) chk_u
(
  .ref_clk_in         (ref_clk_in),
  .rst_b_in           (rst_b_in),
  .pc_load_in         (pc_load_in),
  .pc_load_val_in     (pc_load_val_in),
  .irq_take_in        (irq_take_in),
  .bank_select_bit_in (bank_select_bit_in),
  .dacc_in            (dacc_in),
  .dacc_indirect_in   (dacc_indirect_in),
  .dir_addr_in        (dir_addr_in),
  .pc_out             (pc_out),
  .fetch_addr_out     (fetch_addr_out),
  .sfr_sel_out        (sfr_sel_out),
  .drdata_out         (drdata_out),
  .dvalid_out         (dvalid_out)
);

/* verification/tb_memory_map_bank_decode.sv */
module tb_memory_map_bank_decode;
  timeunit 1ns;
  timeprecision 1ns;
  import mmbd_pkg::*;
  logic ref_clk_in, rst_b_in, pc_load_in, pc_inc_in, irq_take_in, bank_select_bit_in, dacc_in, dacc_indirect_in;
  logic dwrite_in, upper_bank_select_bit_in, indirect_bank_bit_in;
  logic [12:0] pc_load_val_in, pc_exp, pc[2], fa[2];
  logic [6:0] dir_addr_in;
  logic [7:0] file_select_pointer_in, dwdata_in, rd[2], sd[2], mem[256], a;
  logic [4:0] sa[2];
  logic dv[2], ss[2], sw[2];
  int error_cnt, tests_run;
  // ----------------------------------------
  // both memory sizes side by side
  // ----------------------------------------
  for (genvar g = 0; g < 2; g++)
  begin : gen_m
    logic [12:0] pc_out, fetch_addr_out;
    logic [7:0] sfr_rdata_in, sfr_wdata_out, drdata_out;
    logic [4:0] sfr_addr_out;
    logic sfr_sel_out, sfr_we_out, dvalid_out;
    mmbd_top #(.LARGE_MEM(g == 1)) dut_u
    (
      .ref_clk_in               (ref_clk_in),
      .rst_b_in                 (rst_b_in),
      .pc_load_in               (pc_load_in),
      .pc_load_val_in           (pc_load_val_in),
      .pc_inc_in                (pc_inc_in),
      .irq_take_in              (irq_take_in),
      .bank_select_bit_in       (bank_select_bit_in),
      .upper_bank_select_bit_in (upper_bank_select_bit_in),
      .indirect_bank_bit_in     (indirect_bank_bit_in),
      .dacc_in                  (dacc_in),
      .dacc_indirect_in         (dacc_indirect_in),
      .dir_addr_in              (dir_addr_in),
      .file_select_pointer_in   (file_select_pointer_in),
      .dwrite_in                (dwrite_in),
      .dwdata_in                (dwdata_in),
      .sfr_rdata_in             (sfr_rdata_in),
      .pc_out                   (pc_out),
      .fetch_addr_out           (fetch_addr_out),
      .sfr_sel_out              (sfr_sel_out),
      .sfr_we_out               (sfr_we_out),
      .sfr_addr_out             (sfr_addr_out),
      .sfr_wdata_out            (sfr_wdata_out),
      .drdata_out               (drdata_out),
      .dvalid_out               (dvalid_out)
    );
    mmbd_sfr_model sfr_u (.sfr_addr_in(sfr_addr_out), .sfr_rdata_out(sfr_rdata_in));
    assign pc[g] = pc_out;
    assign fa[g] = fetch_addr_out;
    assign rd[g] = drdata_out;
    assign dv[g] = dvalid_out;
    assign sa[g] = sfr_addr_out;
    assign ss[g] = sfr_sel_out;
    assign sw[g] = sfr_we_out;
    assign sd[g] = sfr_wdata_out;
  end
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic int kind(bit lg, logic [7:0] x);
    if (x[6:0] < 7'h20) return 1;
    return (lg || (!x[7] && x[6:0] >= 7'h40) || x >= 8'hF0) ? 2 : 0;
  endfunction : kind
  // program counter step; software keeps reserved status bits at zero
  task automatic step(bit i, bit l, bit n, logic [12:0] v);
    {irq_take_in, pc_load_in, pc_inc_in, pc_load_val_in, dacc_in} = {i, l, n, v, 1'b0};
    pc_exp = i ? IRQ_VEC : l ? v : n ? pc_exp + 13'h0001 : pc_exp;
    @(negedge ref_clk_in);
    for (int g = 0; g < 2; g++)
    begin
      chk(pc[g], pc_exp);
      chk(dv[g], 0);
      chk(fa[g], pc_exp & (g ? 13'h07FF : 13'h03FF));
    end
  endtask : step
  // one data access; direct fields are noise when the pointer is used
  task automatic acc(bit w, logic [7:0] x, logic [7:0] d);
    int k;
    logic [7:0] c, e;
    c = (x >= 8'hF0) ? x - 8'h80 : x;
    dacc_indirect_in = 1'($urandom);
    file_select_pointer_in = dacc_indirect_in ? x : 8'($urandom);
    {bank_select_bit_in, dir_addr_in} = dacc_indirect_in ? 8'($urandom) : x;
    {dacc_in, dwrite_in, dwdata_in} = {1'b1, w, d};
    @(negedge ref_clk_in);
    for (int g = 0; g < 2; g++)
    begin
      k = kind(g == 1, x);
      e = k == 1 ? {3'h5, x[4:0]} : k == 0 ? 8'h00 : mem[c];
      chk(dv[g], 1);
      chk(ss[g], k == 1);
      chk(sw[g], w && k == 1);
      if (k == 1) chk(sa[g], x[4:0]);
      if (k == 1 && w) chk(sd[g], d);
      if (!w) chk(rd[g], e);
    end
    // one model serves both sizes: the small one never reads cells it lacks
    if (w && kind(1, x) == 2) mem[c] = d;
  endtask : acc
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial
  begin
    ref_clk_in = 0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  // ----------------------------------------
  // reset, program counter, then data traffic
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'hA039D491));
    {rst_b_in, pc_load_in, pc_inc_in, irq_take_in, bank_select_bit_in, dacc_in, dacc_indirect_in} = 0;
    {dwrite_in, upper_bank_select_bit_in, indirect_bank_bit_in, pc_load_val_in, dir_addr_in} = 0;
    {file_select_pointer_in, dwdata_in, pc_exp, error_cnt, tests_run} = 0;
    repeat (4) @(negedge ref_clk_in);
    rst_b_in = 1;
    step(0, 0, 0, 13'h0000);
    step(0, 1, 0, 13'h1FFF);
    step(0, 0, 1, 13'h0000);
    step(1, 1, 1, 13'h0123);
    repeat (200) step($urandom % 8 == 0, $urandom % 3 == 0, 1'($urandom), 13'($urandom));
    for (int i = 0; i < 256; i++) acc(1, 8'(i), 8'($urandom));
    repeat (300)
    begin
      a = $urandom;
      acc(1, a, 8'($urandom));
      acc(0, a[6:4] == 3'h7 ? {~a[7], a[6:0]} : a, 8'h00);
      acc(0, 8'($urandom), 8'h00);
    end
    wrap_up();
  end
endmodule : tb_memory_map_bank_decode
